// >>> hdl/lcdhp_pkg.sv
// lcdhp_pkg: constants and types shared by the lcd driver host port
// assumes: 8-bit host data bus, one system clock, serial link clocked by the host
package lcdhp_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int SER_CNT_W = 3;
  localparam logic [SER_CNT_W-1:0] SER_LAST = 3'h7;
  localparam logic [SER_CNT_W-1:0] SER_CNT_RST = 3'h0;
  localparam logic [DATA_W-1:0] SER_SHIFT_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ------------------------------------------------------------------
  // synchroniser vector layout (pins sampled into the system clock)
  // ------------------------------------------------------------------
  localparam int IX_CS = 0;
  localparam int IX_TGT = 1;
  localparam int IX_RD = 2;
  localparam int IX_WR = 3;
  localparam int IX_IF = 4;
  localparam int IX_FAM = 5;
  localparam int IX_TSEL = 6;
  localparam int IX_EXT = 7;
  localparam int IX_TOG = 8;
  localparam int IX_DATA = 9;
  localparam int SYNC_W = IX_DATA + DATA_W;
  // chip select and both strobes idle high
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0000d;

  // ------------------------------------------------------------------
  // target select encoding
  // ------------------------------------------------------------------
  localparam logic TGT_RAM = 1'b0;
  localparam logic TGT_REG = 1'b1;

  // ------------------------------------------------------------------
  // internal display timing oscillator
  // ------------------------------------------------------------------
  localparam int OSC_CNT_W = 16;
  localparam int OSC_HALF_DEFAULT = 4;
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_RST = 16'h0000;

  // ------------------------------------------------------------------
  // parallel read sequencing
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_FETCH = 2'b01,
    PS_DRIVE = 2'b10
  } lcdhp_port_e;

endpackage : lcdhp_pkg

// >>> hdl/lcdhp_host_port.sv
// lcdhp_host_port: host bus port of a grey-scale lcd driver (parallel 80/68 style or serial write-only)
// assumes: pins are asynchronous to clock; serial_clock is the same pad as data pin 0 in serial mode;
// the core behind answers a read request with rd_data in the same cycle as rd_req.
//
// Contract
// RULE_01 - chip_init_low low returns all internal state to defaults.
// RULE_02 - interface select high picks the parallel bus, low the serial path.
// RULE_03 - parallel mode uses the eight data pins as a bidirectional byte bus.
// RULE_04 - serial mode: data pin 0 is shift clock, data pin 1 serial data.
// RULE_05 - serial data is sampled on every rising shift clock edge.
// RULE_06 - eighth rising shift clock edge turns the shifted bits into one processed byte.
// RULE_07 - host keeps the shift clock low after each transfer and when idle.
// RULE_08 - accesses are taken only while chip_select_low is low, ignored while high.
// RULE_09 - target_select 0 routes the byte to display ram, 1 to control registers.
// RULE_10 - family select low: drive data bus while read_strobe_low is low.
// RULE_11 - family select low: latch data bus on rising write_strobe_low.
// RULE_12 - family select high, direction high: drive data bus while enable is high.
// RULE_13 - family select high, direction low: latch data bus on falling enable.
// RULE_14 - host ties the bus family select to a fixed level.
// RULE_15 - serial path is write only, no read back.
// RULE_16 - timing source select high uses external timing input, low internal oscillator.
// RULE_17 - host holds external timing input low when internal oscillator is used.
// RULE_18 - serial mode: host ties unused strobes fixed and leaves unused data pins floating.
// RULE_19 - chip select high holds serial shift register and bit counter cleared.
// RULE_20 - serial bits go most significant first, bit 7 down to bit 0.
// RULE_21 - data pins stay released whenever no read is in progress.
`timescale 1ns/1ps

module lcdhp_host_port #(
  parameter int OSC_HALF = lcdhp_pkg::OSC_HALF_DEFAULT
) (
  // system
  input wire logic clock,
  input wire logic rst_n,
  // host control pins
  input wire logic chip_init_low,
  input wire logic chip_select_low,
  input wire logic target_select,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic interface_select,
  input wire logic bus_family_select,
  // host data pins (three signals per pad)
  input wire logic [lcdhp_pkg::DATA_W-1:0] data_in,
  output logic [lcdhp_pkg::DATA_W-1:0] data_out,
  output logic [lcdhp_pkg::DATA_W-1:0] data_oe,
  // serial shift clock, the data pin 0 pad
  input wire logic serial_clock,
  // display timing
  input wire logic timing_source_select,
  input wire logic external_timing_input,
  output logic display_timing_clock,
  // core side: writes
  output logic wr_valid,
  output logic [lcdhp_pkg::DATA_W-1:0] wr_data,
  output logic wr_target,
  // core side: reads
  output logic rd_req,
  output logic rd_target,
  input wire logic [lcdhp_pkg::DATA_W-1:0] rd_data
);
  import lcdhp_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (OSC_HALF < 1 || OSC_HALF >= (1 << OSC_CNT_W)) begin : g_osc_chk
    $error("OSC_HALF out of range");
  end

  // either reset pin initialises the port
  logic init_n;
  assign init_n = rst_n & chip_init_low; // RULE_01

  // ------------------------------------------------------------------
  // serial link domain
  // ------------------------------------------------------------------
  // chip select high clears the shifter asynchronously, so a stray
  // clock between frames can never leave a partial byte behind
  logic ser_arst_n;
  logic [DATA_W-1:0] ser_shift_reg;
  logic [DATA_W-1:0] ser_shift_next;
  logic [SER_CNT_W-1:0] ser_cnt_reg;
  logic [SER_CNT_W-1:0] ser_cnt_next;
  logic [DATA_W-1:0] ser_word_reg;
  logic [DATA_W-1:0] ser_word_next;
  logic ser_tgt_reg;
  logic ser_tgt_next;
  logic ser_tog_reg;
  logic ser_tog_next;

  assign ser_arst_n = init_n & ~chip_select_low; // RULE_19

  always_comb begin
    ser_shift_next = {ser_shift_reg[DATA_W-2:0], data_in[1]}; // RULE_04 RULE_05 RULE_20
    ser_cnt_next = ser_cnt_reg + 3'h1;
    ser_word_next = ser_word_reg;
    ser_tgt_next = ser_tgt_reg;
    ser_tog_next = ser_tog_reg;
    if (ser_cnt_reg == SER_LAST) begin
      ser_word_next = {ser_shift_reg[DATA_W-2:0], data_in[1]}; // RULE_06
      ser_tgt_next = target_select; // RULE_09
      ser_tog_next = ~ser_tog_reg;
      ser_cnt_next = SER_CNT_RST;
    end
  end

  always_ff @(posedge serial_clock or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      ser_shift_reg <= SER_SHIFT_RST;
      ser_cnt_reg <= SER_CNT_RST;
    end else begin
      ser_shift_reg <= ser_shift_next;
      ser_cnt_reg <= ser_cnt_next;
    end
  end

  // the finished byte survives chip select release until it has crossed
  always_ff @(posedge serial_clock or negedge init_n) begin
    if (!init_n) begin
      ser_word_reg <= DATA_RST;
      ser_tgt_reg <= TGT_RAM;
      ser_tog_reg <= 1'b0;
    end else begin
      ser_word_reg <= ser_word_next;
      ser_tgt_reg <= ser_tgt_next;
      ser_tog_reg <= ser_tog_next;
    end
  end

  // ------------------------------------------------------------------
  // system domain: synchronisers and edge history
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] prev_reg;

  assign pins_raw = {data_in, ser_tog_reg, external_timing_input, timing_source_select,
                     bus_family_select, interface_select, write_strobe_low, read_strobe_low,
                     target_select, chip_select_low};

  // every pin passes two flops; prev_reg gives one more sample for edges
  always_ff @(posedge clock or negedge init_n) begin
    if (!init_n) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      prev_reg <= SYNC_RST;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ------------------------------------------------------------------
  // system domain: access decode
  // ------------------------------------------------------------------
  logic par_mode;
  logic fam68;
  logic cs_now;
  logic cs_was;
  logic rd_act;
  logic par_wr_evt;
  logic ser_evt;

  assign par_mode = sync2_reg[IX_IF]; // RULE_02
  assign fam68 = sync2_reg[IX_FAM];
  assign cs_now = ~sync2_reg[IX_CS]; // RULE_08
  assign cs_was = ~prev_reg[IX_CS]; // RULE_08

  // in 68 style the read pad carries enable and the write pad the direction
  assign rd_act = par_mode & cs_now & // RULE_15
                  ((~fam68 & ~sync2_reg[IX_RD]) | // RULE_10
                   (fam68 & sync2_reg[IX_WR] & sync2_reg[IX_RD])); // RULE_12
  assign par_wr_evt = par_mode & cs_was &
                      ((~fam68 & sync2_reg[IX_WR] & ~prev_reg[IX_WR]) | // RULE_11
                       (fam68 & ~prev_reg[IX_WR] & prev_reg[IX_RD] & ~sync2_reg[IX_RD])); // RULE_13
  // serial bytes are dropped if the port is strapped parallel
  assign ser_evt = ~par_mode & (sync2_reg[IX_TOG] ^ prev_reg[IX_TOG]);

  // ------------------------------------------------------------------
  // system domain: write path and read sequencing
  // ------------------------------------------------------------------
  lcdhp_port_e state_reg;
  lcdhp_port_e state_next;
  logic wr_valid_reg;
  logic wr_valid_next;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_data_next;
  logic wr_target_reg;
  logic wr_target_next;
  logic rd_req_reg;
  logic rd_req_next;
  logic rd_target_reg;
  logic rd_target_next;
  logic [DATA_W-1:0] data_out_reg;
  logic [DATA_W-1:0] data_out_next;
  logic oe_reg;
  logic oe_next;

  always_comb begin
    state_next = state_reg;
    wr_valid_next = 1'b0;
    wr_data_next = wr_data_reg;
    wr_target_next = wr_target_reg;
    rd_req_next = 1'b0;
    rd_target_next = rd_target_reg;
    data_out_next = data_out_reg;
    oe_next = 1'b0;
    // data taken from the sample before the strobe edge, which met setup
    if (par_wr_evt) begin
      wr_valid_next = 1'b1;
      wr_data_next = prev_reg[IX_DATA +: DATA_W]; // RULE_03 RULE_11 RULE_13
      wr_target_next = prev_reg[IX_TGT]; // RULE_09
    end else if (ser_evt) begin
      wr_valid_next = 1'b1;
      wr_data_next = ser_word_reg; // RULE_06
      wr_target_next = ser_tgt_reg; // RULE_09
    end
    case (state_reg)
      PS_IDLE: begin
        if (rd_act) begin
          state_next = PS_FETCH;
          rd_req_next = 1'b1;
          rd_target_next = sync2_reg[IX_TGT]; // RULE_09
        end
      end
      PS_FETCH: begin
        data_out_next = rd_data;
        oe_next = rd_act; // RULE_10 RULE_12
        state_next = rd_act ? PS_DRIVE : PS_IDLE;
      end
      PS_DRIVE: begin
        oe_next = rd_act; // RULE_21
        state_next = rd_act ? PS_DRIVE : PS_IDLE;
      end
      default: begin
        state_next = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge init_n) begin
    if (!init_n) begin
      state_reg <= PS_IDLE;
      wr_valid_reg <= 1'b0;
      wr_data_reg <= DATA_RST;
      wr_target_reg <= TGT_RAM;
      rd_req_reg <= 1'b0;
      rd_target_reg <= TGT_RAM;
      data_out_reg <= DATA_RST;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wr_valid_reg <= wr_valid_next;
      wr_data_reg <= wr_data_next;
      wr_target_reg <= wr_target_next;
      rd_req_reg <= rd_req_next;
      rd_target_reg <= rd_target_next;
      data_out_reg <= data_out_next;
      oe_reg <= oe_next;
    end
  end

  // ------------------------------------------------------------------
  // display timing clock source
  // ------------------------------------------------------------------
  // the internal oscillator is modelled as a divider of the system clock
  localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_HALF - 1);
  logic [OSC_CNT_W-1:0] osc_cnt_reg;
  logic [OSC_CNT_W-1:0] osc_cnt_next;
  logic osc_reg;
  logic osc_next;
  logic tclk_reg;
  logic tclk_next;

  always_comb begin
    osc_cnt_next = osc_cnt_reg + 16'h0001;
    osc_next = osc_reg;
    if (osc_cnt_reg == OSC_LAST) begin
      osc_cnt_next = OSC_CNT_RST;
      osc_next = ~osc_reg;
    end
    tclk_next = sync2_reg[IX_TSEL] ? sync2_reg[IX_EXT] : osc_reg; // RULE_16
  end

  always_ff @(posedge clock or negedge init_n) begin
    if (!init_n) begin
      osc_cnt_reg <= OSC_CNT_RST;
      osc_reg <= 1'b0;
      tclk_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      osc_reg <= osc_next;
      tclk_reg <= tclk_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign data_out = data_out_reg;
  assign data_oe = {DATA_W{oe_reg}}; // RULE_21
  assign display_timing_clock = tclk_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_data = wr_data_reg;
  assign wr_target = wr_target_reg;
  assign rd_req = rd_req_reg;
  assign rd_target = rd_target_reg;

endmodule : lcdhp_host_port

// >>> dv/lcdhp_host_port_properties.sv
// port checker for the lcd host port
// assumes: bound to every lcdhp_host_port, pins sampled on the rising system clock
`timescale 1ns/1ps
module lcdhp_host_port_properties (
  // system
  input logic clock,
  input logic rst_n,
  input logic chip_init_low,
  // host pins
  input logic chip_select_low,
  input logic read_strobe_low,
  input logic write_strobe_low,
  input logic interface_select,
  input logic bus_family_select,
  input logic timing_source_select,
  input logic external_timing_input,
  // port outputs and core data
  input logic [lcdhp_pkg::DATA_W-1:0] data_out,
  input logic [lcdhp_pkg::DATA_W-1:0] data_oe,
  input logic display_timing_clock,
  input logic wr_valid,
  input logic rd_req,
  input logic [lcdhp_pkg::DATA_W-1:0] rd_data
);
  import lcdhp_pkg::*;
  logic on80;
  logic on68;
  assign on80 = interface_select && !bus_family_select && !chip_select_low;
  assign on68 = interface_select && bus_family_select && !chip_select_low;
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n || !chip_init_low);
  property p_reset; disable iff (1'b0) !(rst_n && chip_init_low) |-> data_oe == 8'h00 && !wr_valid && !rd_req; endproperty
  a_reset: assert property (p_reset) else $error("outputs active in reset");
  property p_cs; chip_select_low [*6] |-> !wr_valid && !rd_req; endproperty
  a_cs: assert property (p_cs) else $error("access while deselected");
  property p_wr80; $rose(write_strobe_low) && on80 |-> ##[1:4] wr_valid; endproperty
  a_wr80: assert property (p_wr80) else $error("strobe write lost");
  property p_wr68; $fell(read_strobe_low) && !write_strobe_low && on68 |-> ##[1:4] wr_valid; endproperty
  a_wr68: assert property (p_wr68) else $error("enable write lost");
  property p_rd80; $fell(read_strobe_low) && on80 |-> ##[1:4] rd_req; endproperty
  a_rd80: assert property (p_rd80) else $error("strobe read lost");
  property p_rd68; $rose(read_strobe_low) && write_strobe_low && on68 |-> ##[1:4] rd_req; endproperty
  a_rd68: assert property (p_rd68) else $error("enable read lost");
  property p_drive; rd_req |=> data_oe == 8'hff && data_out == $past(rd_data); endproperty
  a_drive: assert property (p_drive) else $error("read data not driven");
  // the strobe level that means idle flips with the bus family
  property p_release; (read_strobe_low ^ bus_family_select) [*5] |-> data_oe == 8'h00; endproperty
  a_release: assert property (p_release) else $error("pads driven while idle");
  property p_serial; !interface_select [*5] |-> data_oe == 8'h00; endproperty
  a_serial: assert property (p_serial) else $error("serial path drove pads");
  property p_ext; timing_source_select [*6] |-> display_timing_clock == $past(external_timing_input, 3); endproperty
  a_ext: assert property (p_ext) else $error("timing clock not external");
  c_wr: cover property (wr_valid);
  c_rd: cover property (rd_req);
  c_ext: cover property (timing_source_select && $changed(display_timing_clock));
endmodule : lcdhp_host_port_properties

bind lcdhp_host_port lcdhp_host_port_properties i_props (.clock, .rst_n, .chip_init_low, .chip_select_low,
  .read_strobe_low, .write_strobe_low, .interface_select, .bus_family_select, .timing_source_select,
  .external_timing_input, .data_out, .data_oe, .display_timing_clock, .wr_valid, .rd_req, .rd_data);

// >>> dv/lcdhp_host_model.sv
// host model: parallel bus master or serial master on the port's pins
// assumes: pad levels resolved here from the port's enables; data_in[0] is the serial clock pad
`timescale 1ns/1ps
module lcdhp_host_model (
  // system
  input logic clock,
  // host pins
  output logic chip_select_low,
  output logic target_select,
  output logic read_strobe_low,
  output logic write_strobe_low,
  output logic interface_select,
  output logic bus_family_select,
  output logic serial_clock,
  output logic [lcdhp_pkg::DATA_W-1:0] data_in,
  // port pad drive
  input logic [lcdhp_pkg::DATA_W-1:0] data_out,
  input logic [lcdhp_pkg::DATA_W-1:0] data_oe
);
  import lcdhp_pkg::*;
  logic [DATA_W-1:0] hd;
  logic [5:0] noise;
  logic sda;
  initial begin
    {chip_select_low, target_select, read_strobe_low, write_strobe_low} = 4'hb;
    {interface_select, bus_family_select, serial_clock, sda} = 4'h8;
    hd = 8'h00;
    noise = 6'h00;
  end
  // floating pads change every cycle so a stale value never passes
  always @(posedge clock) noise <= noise + 6'h01;
  always_comb data_in = data_oe[0] ? data_out : (interface_select ? hd : {noise, sda, serial_clock});
  task automatic mode(input logic ps, input logic fam);
    @(posedge clock);
    interface_select <= ps;
    bus_family_select <= fam;
    // serial mode ties the read pad low for good, so a stray read condition stands for the whole run
    read_strobe_low <= ps ? !fam : 1'b0;
    write_strobe_low <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : mode
  task automatic wr(input logic c, input logic t, input logic [7:0] d);
    @(posedge clock);
    chip_select_low <= c;
    target_select <= t;
    hd <= d;
    write_strobe_low <= 1'b0;
    if (bus_family_select) read_strobe_low <= 1'b1;
    repeat (3) @(posedge clock);
    if (bus_family_select) read_strobe_low <= 1'b0;
    else write_strobe_low <= 1'b1;
    repeat (3) @(posedge clock);
    write_strobe_low <= 1'b1;
    chip_select_low <= 1'b1;
    hd <= ~d;
  endtask : wr
  task automatic rd(input logic c, input logic t, output logic [7:0] q);
    @(posedge clock);
    chip_select_low <= c;
    target_select <= t;
    if (interface_select) read_strobe_low <= bus_family_select;
    repeat (8) @(posedge clock);
    q = data_in;
    if (interface_select) read_strobe_low <= !bus_family_select;
    chip_select_low <= 1'b1;
    repeat (5) @(posedge clock);
  endtask : rd
  // link clock of 32 ns, offset so it never meets a rising system clock edge
  task automatic ser(input logic t, input logic [7:0] d, input int n);
    @(posedge clock);
    chip_select_low <= 1'b0;
    target_select <= t;
    #7;
    for (int i = 7; i > 7 - n; i--) begin
      sda = d[i];
      #16 serial_clock = 1'b1;
      #16 serial_clock = 1'b0;
    end
    repeat (8) @(posedge clock);
    chip_select_low <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : ser
endmodule : lcdhp_host_model

// >>> dv/lcdhp_host_port_test.sv
// self-checking bench for lcdhp_host_port with a host model on its pins
// assumes: core read data supplied here, internal oscillator half period shortened to two cycles
`timescale 1ns/1ps
module lcdhp_host_port_test;
  import lcdhp_pkg::*;
  localparam int HALF = 2;
  logic clock, rst_n, chip_init_low, timing_source_select, external_timing_input, chip_select_low, target_select;
  logic read_strobe_low, write_strobe_low, interface_select, bus_family_select, serial_clock;
  logic display_timing_clock, wr_valid, wr_target, rd_req, rd_target;
  logic [DATA_W-1:0] data_in, data_out, data_oe, wr_data, rd_data, q;
  logic [8:0] wq[$];
  int err_total = 0;
  int comparisons = 0;
  int n_rd = 0;
  lcdhp_host_port #(.OSC_HALF(HALF)) i_dut (.clock, .rst_n, .chip_init_low, .chip_select_low, .target_select,
    .read_strobe_low, .write_strobe_low, .interface_select, .bus_family_select, .data_in, .data_out, .data_oe,
    .serial_clock, .timing_source_select, .external_timing_input, .display_timing_clock, .wr_valid, .wr_data,
    .wr_target, .rd_req, .rd_target, .rd_data);
  lcdhp_host_model i_host (.clock, .chip_select_low, .target_select, .read_strobe_low, .write_strobe_low,
    .interface_select, .bus_family_select, .serial_clock, .data_in, .data_out, .data_oe);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wr_valid === 1'b1) wq.push_back({wr_target, wr_data});
    if (rd_req === 1'b1) n_rd <= n_rd + 1;
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_check(input int n, input logic [8:0] a, input logic [8:0] b);
    repeat (6) @(posedge clock);
    check("write count", 9'(wq.size()), 9'(n));
    if (wq.size() > 0) check("first write", wq.pop_front(), a);
    if (wq.size() > 0) check("second write", wq.pop_front(), b);
    wq.delete();
  endtask : wr_check
  task automatic t_timing();
    int n;
    logic last;
    n = 0;
    repeat (8) @(posedge clock);
    last = display_timing_clock;
    repeat (40) begin
      @(posedge clock);
      if (display_timing_clock !== last) n++;
      last = display_timing_clock;
    end
    check("oscillator edges", 9'(n), 9'(40 / HALF));
    timing_source_select <= 1'b1;
    repeat (8) @(posedge clock);
    for (int i = 0; i < 2; i++) begin
      external_timing_input <= !i[0];
      repeat (5) @(posedge clock);
      check("external timing", {8'h00, display_timing_clock}, {8'h00, !i[0]});
    end
    timing_source_select <= 1'b0;
    external_timing_input <= 1'b0;
  endtask : t_timing
  task automatic t_par(input logic fam);
    int n0;
    i_host.mode(1'b1, fam);
    i_host.wr(1'b0, 1'b0, 8'h5a);
    i_host.wr(1'b0, 1'b1, 8'ha5);
    wr_check(2, 9'h05a, 9'h1a5);
    n0 = n_rd;
    i_host.wr(1'b1, 1'b0, 8'h77);
    i_host.rd(1'b1, 1'b0, q);
    wr_check(0, 9'h000, 9'h000);
    rd_data <= 8'h3c;
    i_host.rd(1'b0, 1'b1, q);
    check("read data", {1'b0, q}, 9'h03c);
    check("read target", {8'h00, rd_target}, 9'h001);
    check("read count", 9'(n_rd - n0), 9'h001);
    check("pads after read", {1'b0, data_oe}, 9'h000);
  endtask : t_par
  task automatic t_ser();
    int n0;
    i_host.mode(1'b0, 1'b0);
    i_host.ser(1'b1, 8'hc3, 8);
    wr_check(1, 9'h1c3, 9'h000);
    i_host.ser(1'b0, 8'hff, 5);
    i_host.ser(1'b0, 8'h81, 8);
    wr_check(1, 9'h081, 9'h000);
    n0 = n_rd;
    i_host.rd(1'b0, 1'b0, q);
    check("serial read", 9'(n_rd - n0), 9'h000);
  endtask : t_ser
  task automatic t_init();
    chip_init_low <= 1'b0;
    repeat (2) @(posedge clock);
    check("byte after init", {wr_target, wr_data}, 9'h000);
    chip_init_low <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : t_init
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    {rst_n, chip_init_low, timing_source_select, external_timing_input} = 4'h4;
    rd_data = 8'h00;
    repeat (6) @(posedge clock);
    check("pads in reset", {1'b0, data_oe}, 9'h000);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_timing();
    t_par(1'b0);
    t_par(1'b1);
    t_ser();
    t_init();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test();
  end
endmodule : lcdhp_host_port_test
